// *** rtl/ftc_pkg.sv ***
// Package of constants and types for the frame trigger control block.
// What this block does
// R1: Long-exposure on forces quick readout off; both never active together.
// R2: Trigger kind is single-frame start or multi-frame burst start.
// R3: Multi-frame trigger acquires exactly burst_frame_total frames, one when it is zero; used only in multi-frame kind.
// R4: External triggering off: frames paced by frame-rate tick, all trigger sources ignored.
// R5: External triggering on: frames start only from the selected origin.
// R6: Origin is input one, input two, link, timer one, counter one or software.
// R7: Frame grabber delivers link triggers on camera link trigger channel zero.
// R8: Timer one or counter one expiry serves directly as the frame trigger.
// R9: Software command triggers only with software origin; then nothing else triggers.
// R10: Source qualified on rising, falling or either edge per edge selection.
// R11: Qualified trigger waits programmed microsecond delay before frame trigger event.
// R12: Retrigger policy decides if trigger during active frame is accepted.
// R13: Overlap off: triggers during a frame in progress are rejected.
// R14: Readout overlap: new trigger accepted once current readout has begun.
// R15: Line pick addresses six lines: two inputs, then four outputs.
// R16: Refused trigger raises invalid-frame-trigger pulse usable as output source.
// R17: One-microsecond tick times delay; rearm after burst delivers full count.
package ftc_pkg;

  localparam int CLK_HZ          = 20000000;
  localparam int US_PER_S        = 1000000;
  localparam int CYC_PER_US      = CLK_HZ / US_PER_S;
  localparam int US_CNT_W        = 5;
  localparam int DELAY_W         = 16;
  localparam int BURST_W         = 16;
  localparam int LINE_PICK_W     = 3;
  localparam int NUM_IN_LINES    = 2;
  localparam int NUM_OUT_LINES   = 4;

  typedef enum logic [0:0] {
    FTC_KIND_SINGLE = 1'h0,
    FTC_KIND_MULTI  = 1'h1
  } ftc_kind_t;

  typedef enum logic [2:0] {
    FTC_ORG_IN_ONE  = 3'h0,
    FTC_ORG_IN_TWO  = 3'h1,
    FTC_ORG_LINK    = 3'h2,
    FTC_ORG_TIMER   = 3'h3,
    FTC_ORG_COUNTER = 3'h4,
    FTC_ORG_SOFT    = 3'h5
  } ftc_origin_t;

  typedef enum logic [1:0] {
    FTC_EDGE_UP     = 2'h0,
    FTC_EDGE_DOWN   = 2'h1,
    FTC_EDGE_EITHER = 2'h2
  } ftc_edge_t;

  typedef enum logic [0:0] {
    FTC_OVL_OFF     = 1'h0,
    FTC_OVL_READOUT = 1'h1
  } ftc_overlap_t;

  typedef enum logic [2:0] {
    FTC_ST_IDLE  = 3'h1,
    FTC_ST_DELAY = 3'h2,
    FTC_ST_FRAME = 3'h4
  } ftc_state_t;

  // Line numbers as software sees them; one and two are inputs.
  localparam logic [LINE_PICK_W-1:0] LINE_FIRST_IN  = 3'h1;
  localparam logic [LINE_PICK_W-1:0] LINE_FIRST_OUT = 3'h3;
  localparam logic [LINE_PICK_W-1:0] LINE_LAST      = 3'h6;

endpackage : ftc_pkg

// *** rtl/ftc_edge_if.sv ***
// Interface carrying the qualified trigger from the edge stage to the control core.
`timescale 1ns/100ps
interface ftc_edge_if;
  logic src_level;
  logic qualified;
  modport detector (input src_level, output qualified);
  modport core     (output src_level, input qualified);
endinterface : ftc_edge_if

// *** rtl/ftc_edge_qual.sv ***
// Edge qualifier that turns a source level into a one-cycle trigger pulse.
`timescale 1ns/100ps
module ftc_edge_qual (
  input  wire logic          core_clk,
  input  wire logic          reset_n,
  input  ftc_pkg::ftc_edge_t edge_sel,
  ftc_edge_if.detector       eif
);

  logic prev_q;
  logic prev_d;
  logic rise;
  logic fall;

  // Next value of the delayed level, plus edge decode.
  always_comb begin
    prev_d = eif.src_level;
    rise   = eif.src_level & ~prev_q;
    fall   = ~eif.src_level & prev_q;
    case (edge_sel) // [R10]
      ftc_pkg::FTC_EDGE_UP:     eif.qualified = rise;
      ftc_pkg::FTC_EDGE_DOWN:   eif.qualified = fall;
      ftc_pkg::FTC_EDGE_EITHER: eif.qualified = rise | fall;
      default:                  eif.qualified = 1'b0;
    endcase
  end

  // Register the previous level.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
    end
  end

endmodule : ftc_edge_qual

// *** rtl/ftc_trigger_ctrl.sv ***
// Top of the frame trigger control: origin select, delay, overlap and burst count.
`timescale 1ns/100ps
module ftc_trigger_ctrl #(
  parameter int DELAY_W = ftc_pkg::DELAY_W,
  parameter int BURST_W = ftc_pkg::BURST_W
) (
  input  wire logic                          core_clk,
  input  wire logic                          reset_n,
  input  ftc_pkg::ftc_kind_t                 frame_trigger_kind_select,
  input  wire logic                          external_trigger_enable,
  input  ftc_pkg::ftc_origin_t               trigger_origin_select,
  input  ftc_pkg::ftc_edge_t                 trigger_edge_select,
  input  wire logic [DELAY_W-1:0]            trigger_postpone_us,
  input  ftc_pkg::ftc_overlap_t              retrigger_policy,
  input  wire logic [BURST_W-1:0]            burst_frame_total,
  input  wire logic                          long_exposure_request,
  input  wire logic                          quick_readout_request,
  input  wire logic                          soft_trigger_command,
  input  wire logic                          timer_one_expiry,
  input  wire logic                          counter_one_expiry,
  input  wire logic                          frame_rate_tick,
  input  wire logic                          input_pin_one,
  input  wire logic                          input_pin_two,
  input  wire logic                          grabber_link_trigger,
  input  wire logic                          readout_started,
  input  wire logic                          frame_done,
  input  wire logic [ftc_pkg::LINE_PICK_W-1:0] physical_line_pick,
  output logic                               long_exposure_mode,
  output logic                               quick_readout_mode,
  output logic                               frame_trigger,
  output logic                               invalid_frame_trigger,
  output logic                               frame_active,
  output logic                               line_pick_is_input,
  output logic                               line_pick_is_output,
  output logic [ftc_pkg::LINE_PICK_W-1:0]    line_pick_index
);

  ftc_edge_if eif ();

  // Two-flop synchronisers for pins and the link; stage one feeds stage two only.
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {grabber_link_trigger, input_pin_two, input_pin_one};
      pin_s2_q <= pin_s1_q;
    end
  end

  // Only line origins go through the edge stage; internal events are already pulses.
  always_comb begin
    case (trigger_origin_select)
      ftc_pkg::FTC_ORG_IN_ONE: eif.src_level = pin_s2_q[0];
      ftc_pkg::FTC_ORG_IN_TWO: eif.src_level = pin_s2_q[1];
      ftc_pkg::FTC_ORG_LINK:   eif.src_level = pin_s2_q[2]; // [R7]
      default:                 eif.src_level = 1'b0;
    endcase
  end

  ftc_edge_qual u_edge (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .edge_sel (trigger_edge_select),
    .eif      (eif)
  );

  // Select exactly one trigger cause; software excludes all others.
  logic raw_trig;
  always_comb begin
    case (trigger_origin_select) // [R6]
      ftc_pkg::FTC_ORG_IN_ONE,
      ftc_pkg::FTC_ORG_IN_TWO,
      ftc_pkg::FTC_ORG_LINK:    raw_trig = eif.qualified; // [R5]
      ftc_pkg::FTC_ORG_TIMER:   raw_trig = timer_one_expiry; // [R8]
      ftc_pkg::FTC_ORG_COUNTER: raw_trig = counter_one_expiry; // [R8]
      ftc_pkg::FTC_ORG_SOFT:    raw_trig = soft_trigger_command; // [R9]
      default:                  raw_trig = 1'b0;
    endcase
    if (!external_trigger_enable) begin
      raw_trig = frame_rate_tick; // [R4]
    end
  end

  // Exposure mode pair; long exposure wins so both are never active.
  always_comb begin
    long_exposure_mode = long_exposure_request;
    quick_readout_mode = quick_readout_request & ~long_exposure_request; // [R1]
  end

  // Line pick decode: one and two are inputs, three to six outputs.
  always_comb begin
    line_pick_index     = physical_line_pick;
    line_pick_is_input  = (physical_line_pick >= ftc_pkg::LINE_FIRST_IN) &&
                          (physical_line_pick < ftc_pkg::LINE_FIRST_OUT); // [R15]
    line_pick_is_output = (physical_line_pick >= ftc_pkg::LINE_FIRST_OUT) &&
                          (physical_line_pick <= ftc_pkg::LINE_LAST); // [R15]
  end

  // Microsecond tick divider; it times the postpone count.
  // It restarts when a delay is loaded, so the wait is whole microseconds and never short.
  logic [ftc_pkg::US_CNT_W-1:0] us_cnt_q;
  logic [ftc_pkg::US_CNT_W-1:0] us_cnt_d;
  logic                         us_tick;
  logic                         us_restart;
  localparam logic [ftc_pkg::US_CNT_W-1:0] US_LAST =
    ftc_pkg::US_CNT_W'(ftc_pkg::CYC_PER_US - 1);
  always_comb begin
    us_tick  = (us_cnt_q == US_LAST); // [R17]
    us_cnt_d = (us_tick || us_restart) ? '0 : us_cnt_q + 1'b1; // [R11]
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      us_cnt_q <= '0;
    end else begin
      us_cnt_q <= us_cnt_d;
    end
  end

  // Trigger sequencer state.
  ftc_pkg::ftc_state_t st_q;
  ftc_pkg::ftc_state_t st_d;
  logic [DELAY_W-1:0]  dly_q;
  logic [DELAY_W-1:0]  dly_d;
  logic [BURST_W-1:0]  left_q;
  logic [BURST_W-1:0]  left_d;
  logic                rdo_q;
  logic                rdo_d;
  logic                pend_q;
  logic                pend_d;
  logic                ft_q;
  logic                ft_d;
  logic                inv_q;
  logic                inv_d;
  logic                accept;
  logic                fire;
  logic [BURST_W-1:0]  total;

  // A trigger is accepted when idle, or during readout with readout overlap while no trigger is latched yet.
  // The overlapped trigger is latched and, at the end of the last burst frame, starts the postpone delay to the next frame,
  // which keeps frames strictly serial at the output while honoring overlap.
  always_comb begin
    st_d   = st_q;
    dly_d  = dly_q;
    left_d = left_q;
    rdo_d  = rdo_q;
    pend_d = pend_q;
    ft_d   = 1'b0;
    inv_d  = 1'b0;
    fire   = 1'b0;
    accept = 1'b0;
    us_restart = 1'b0;
    total  = (frame_trigger_kind_select == ftc_pkg::FTC_KIND_MULTI) ?
             burst_frame_total : BURST_W'(1); // [R2] [R3]
    if (total == '0) begin
      total = BURST_W'(1);
    end
    if (raw_trig) begin
      case (st_q) // [R12]
        ftc_pkg::FTC_ST_IDLE: accept = 1'b1;
        ftc_pkg::FTC_ST_FRAME: accept = (retrigger_policy == ftc_pkg::FTC_OVL_READOUT) &&
                                        (rdo_q || readout_started) && !pend_q; // [R13] [R14]
        default: accept = 1'b0;
      endcase
      inv_d = ~accept; // [R16]
    end
    case (st_q)
      ftc_pkg::FTC_ST_IDLE: begin
        if (accept) begin
          left_d = total;
          dly_d  = trigger_postpone_us;
          us_restart = 1'b1; // [R11]
          st_d   = ftc_pkg::FTC_ST_DELAY;
        end
      end
      ftc_pkg::FTC_ST_DELAY: begin
        if (dly_q == '0) begin
          fire = 1'b1; // [R11]
        end else if (us_tick) begin
          dly_d = dly_q - 1'b1; // [R11]
        end
      end
      ftc_pkg::FTC_ST_FRAME: begin
        if (accept) begin
          pend_d = 1'b1;
        end
        if (readout_started) begin
          rdo_d = 1'b1;
        end
        if (frame_done) begin
          rdo_d = 1'b0;
          if (left_q != '0) begin
            fire = 1'b1; // [R3]
          end else if (pend_q || accept) begin
            pend_d = 1'b0;
            us_restart = 1'b1; // [R11]
            left_d = total;
            dly_d  = trigger_postpone_us;
            st_d   = ftc_pkg::FTC_ST_DELAY;
          end else begin
            st_d = ftc_pkg::FTC_ST_IDLE; // [R17]
          end
        end
      end
      default: st_d = ftc_pkg::FTC_ST_IDLE;
    endcase
    if (fire) begin
      ft_d   = 1'b1;
      left_d = left_d - 1'b1;
      rdo_d  = 1'b0;
      st_d   = ftc_pkg::FTC_ST_FRAME;
    end
  end

  // Register the sequencer.
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q   <= ftc_pkg::FTC_ST_IDLE;
      dly_q  <= '0;
      left_q <= '0;
      rdo_q  <= 1'b0;
      pend_q <= 1'b0;
      ft_q   <= 1'b0;
      inv_q  <= 1'b0;
    end else begin
      st_q   <= st_d;
      dly_q  <= dly_d;
      left_q <= left_d;
      rdo_q  <= rdo_d;
      pend_q <= pend_d;
      ft_q   <= ft_d;
      inv_q  <= inv_d;
    end
  end

  // Outputs from flip-flops.
  always_comb begin
    frame_trigger         = ft_q;
    invalid_frame_trigger = inv_q;
    frame_active          = (st_q == ftc_pkg::FTC_ST_FRAME);
  end

endmodule : ftc_trigger_ctrl

// *** dv/ftc_trigger_ctrl_chk.sv ***
// Port checker for the frame trigger control block.
`timescale 1ns/100ps
module ftc_trigger_ctrl_chk #(
  parameter int DELAY_W = 16,
  parameter int BURST_W = 16
) (
  input wire logic               core_clk,
  input wire logic               reset_n,
  input ftc_pkg::ftc_kind_t      frame_trigger_kind_select,
  input wire logic               external_trigger_enable,
  input ftc_pkg::ftc_origin_t    trigger_origin_select,
  input wire logic [DELAY_W-1:0] trigger_postpone_us,
  input ftc_pkg::ftc_overlap_t   retrigger_policy,
  input wire logic [BURST_W-1:0] burst_frame_total,
  input wire logic               long_exposure_request,
  input wire logic               quick_readout_request,
  input wire logic               soft_trigger_command,
  input wire logic               frame_rate_tick,
  input wire logic               frame_done,
  input wire logic               long_exposure_mode,
  input wire logic               quick_readout_mode,
  input wire logic               frame_trigger,
  input wire logic               invalid_frame_trigger,
  input wire logic               frame_active
);
  logic [BURST_W-1:0] seen_q;
  logic [BURST_W-1:0] seen_d;
  // Frames started in this burst; cleared once the frame window closes.
  always_comb begin
    seen_d = seen_q;
    if (frame_trigger) seen_d = seen_q + 1'b1;
    else if (!frame_active) seen_d = '0;
  end
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) seen_q <= '0;
    else seen_q <= seen_d;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Without delay or overlap, a trigger is refused next cycle or starts a frame after two.
  property p_answer(ev);
    ev && trigger_postpone_us == '0 && retrigger_policy == ftc_pkg::FTC_OVL_OFF
      |-> (##1 invalid_frame_trigger) or (##2 frame_trigger);
  endproperty
  AST_EXCL: assert property (long_exposure_request |-> long_exposure_mode && !quick_readout_mode)
    else $error("quick readout active beside long exposure");
  AST_QUICK: assert property (!long_exposure_request && quick_readout_request |-> quick_readout_mode)
    else $error("quick readout not granted");
  AST_TICK: assert property (p_answer(!external_trigger_enable && frame_rate_tick))
    else $error("frame rate tick not answered");
  AST_SOFT: assert property (p_answer(external_trigger_enable && soft_trigger_command &&
    trigger_origin_select == ftc_pkg::FTC_ORG_SOFT)) else $error("soft trigger not answered");
  AST_SOFT_ONLY: assert property (invalid_frame_trigger && $past(external_trigger_enable) &&
    $past(trigger_origin_select) == ftc_pkg::FTC_ORG_SOFT |-> $past(soft_trigger_command))
    else $error("refusal without soft command");
  AST_START: assert property ($rose(frame_active) |-> frame_trigger)
    else $error("frame active without frame trigger");
  AST_SINGLE_END: assert property (frame_active && frame_done &&
    frame_trigger_kind_select == ftc_pkg::FTC_KIND_SINGLE |=> !frame_active)
    else $error("single frame did not end");
  AST_BURST_NEXT: assert property (frame_active && frame_done && seen_q < burst_frame_total &&
    frame_trigger_kind_select == ftc_pkg::FTC_KIND_MULTI |=> frame_trigger)
    else $error("burst frame not started");
  AST_BURST_CNT: assert property ($fell(frame_active) && burst_frame_total != '0 &&
    frame_trigger_kind_select == ftc_pkg::FTC_KIND_MULTI |-> seen_q == burst_frame_total)
    else $error("burst frame count wrong");
  AST_COV_BURST: cover property (frame_active && frame_done && seen_q == 16'h3);
  AST_COV_REFUSE: cover property (invalid_frame_trigger);
  AST_COV_EXT: cover property (frame_trigger && external_trigger_enable);
endmodule : ftc_trigger_ctrl_chk

bind ftc_trigger_ctrl ftc_trigger_ctrl_chk #(.DELAY_W(DELAY_W), .BURST_W(BURST_W)) chk_u (.*);

// *** dv/ftc_far_model.sv ***
// Far-side model: trigger lines, grabber link trigger and sensor frame timing.
`timescale 1ns/100ps
module ftc_far_model (
  input wire logic       core_clk,
  input wire logic [2:0] line_req,
  input wire logic       frame_trigger,
  output logic           input_pin_one,
  output logic           input_pin_two,
  output logic           grabber_link_trigger,
  output logic           readout_started = 1'b0,
  output logic           frame_done = 1'b0
);
  int hold[3] = '{0, 0, 0};
  int ph = 0;
  // A request holds its line high four cycles so the synchroniser cannot miss it.
  always @(posedge core_clk) begin
    for (int j = 0; j < 3; j++) hold[j] <= line_req[j] ? 4 : (hold[j] > 0 ? hold[j] - 1 : 0);
  end
  assign input_pin_one = hold[0] > 0;
  assign input_pin_two = hold[1] > 0;
  assign grabber_link_trigger = hold[2] > 0;
  // Readout begins four cycles into a frame and the frame ends seven cycles later.
  always @(posedge core_clk) begin
    readout_started <= (ph == 4);
    frame_done <= (ph == 11);
    ph <= (frame_trigger === 1'b1) ? 1 : ((ph == 0 || ph == 11) ? 0 : ph + 1);
  end
endmodule : ftc_far_model

// *** dv/tb_frame_trigger_control.sv ***
// Self-checking bench for the frame trigger control block.
`timescale 1ns/100ps
module tb_frame_trigger_control;
  logic core_clk = 1'b0, reset_n = 1'b0, external_trigger_enable = 1'b0;
  ftc_pkg::ftc_kind_t frame_trigger_kind_select = ftc_pkg::FTC_KIND_SINGLE;
  ftc_pkg::ftc_origin_t trigger_origin_select = ftc_pkg::FTC_ORG_SOFT;
  ftc_pkg::ftc_edge_t trigger_edge_select = ftc_pkg::FTC_EDGE_UP;
  ftc_pkg::ftc_overlap_t retrigger_policy = ftc_pkg::FTC_OVL_OFF;
  logic [15:0] trigger_postpone_us = 16'h0, burst_frame_total = 16'h1;
  logic long_exposure_request = 1'b0, quick_readout_request = 1'b0, soft_trigger_command = 1'b0;
  logic timer_one_expiry = 1'b0, counter_one_expiry = 1'b0, frame_rate_tick = 1'b0;
  logic [2:0] line_req = 3'h0, physical_line_pick = 3'h1, line_pick_index;
  logic input_pin_one, input_pin_two, grabber_link_trigger, readout_started, frame_done;
  logic long_exposure_mode, quick_readout_mode, frame_trigger, invalid_frame_trigger;
  logic frame_active, line_pick_is_input, line_pick_is_output;
  int bad_count = 0, checks = 0, ft_n = 0, inv_n = 0, i, k, n0, v0;
  // Rows: enable, origin, source (tick, soft, timer, counter, pin1, pin2, link), frames.
  int rows[13][4] = '{'{0, 5, 0, 1}, '{0, 5, 1, 0}, '{1, 5, 0, 0}, '{1, 5, 1, 1},
    '{1, 3, 1, 0}, '{1, 3, 2, 1}, '{1, 4, 3, 1}, '{1, 4, 2, 0}, '{1, 0, 4, 1},
    '{1, 0, 5, 0}, '{1, 1, 5, 1}, '{1, 2, 6, 1}, '{1, 2, 4, 0}};
  ftc_trigger_ctrl dut_u (.*);
  ftc_far_model far_u (.*);
  initial forever #25 core_clk = ~core_clk;
  // Pulses are counted, so a doubled or missing pulse shows in the totals.
  always @(posedge core_clk) begin
    if (frame_trigger === 1'b1) ft_n++;
    if (invalid_frame_trigger === 1'b1) inv_n++;
  end
  task automatic finish_test;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %0d seen %0d", w, e, g);
    end
  endtask : chk
  task automatic fire(input int s);
    @(posedge core_clk);
    case (s)
      0: frame_rate_tick <= 1'b1;
      1: soft_trigger_command <= 1'b1;
      2: timer_one_expiry <= 1'b1;
      3: counter_one_expiry <= 1'b1;
      default: line_req[s-4] <= 1'b1;
    endcase
    @(posedge core_clk);
    {frame_rate_tick, soft_trigger_command, timer_one_expiry, counter_one_expiry} <= 4'h0;
    line_req <= 3'h0;
  endtask : fire
  // A wait that used up its bound is a hang: count it and close the run.
  task automatic bound_check(input string w, input int n);
    if (n >= 400) begin
      bad_count++;
      $display("[FAIL] %s expected below 400 seen %0d", w, n);
      finish_test();
    end
  endtask : bound_check
  // Quiet period, then a bounded wait for the frame to close; a hang ends the run.
  task automatic settle;
    int m;
    repeat (30) @(posedge core_clk);
    for (m = 0; m < 400 && frame_active !== 1'b0; m++) @(posedge core_clk);
    bound_check("frame_end_wait", m);
  endtask : settle
  task automatic run(input int s, input int ef, input int ei);
    n0 = ft_n;
    v0 = inv_n;
    fire(s);
    settle();
    chk("frames", ef, ft_n - n0);
    chk("refused", ei, inv_n - v0);
  endtask : run
  initial begin
    repeat (10) @(posedge core_clk);
    chk("reset_active", 32'h0, {31'h0, frame_active});
    reset_n <= 1'b1;
    for (i = 0; i < 13; i++) begin
      @(posedge core_clk);
      external_trigger_enable <= rows[i][0][0];
      trigger_origin_select <= ftc_pkg::ftc_origin_t'(rows[i][1]);
      run(rows[i][2], rows[i][3], 0);
    end
    // Falling, either and unused edge codes on input one.
    trigger_origin_select <= ftc_pkg::FTC_ORG_IN_ONE;
    for (i = 1; i < 4; i++) begin
      trigger_edge_select <= ftc_pkg::ftc_edge_t'(i);
      run(4, i < 3, i == 2);
    end
    trigger_origin_select <= ftc_pkg::FTC_ORG_SOFT;
    trigger_postpone_us <= 16'h3;
    fire(1);
    // Two cycles of pipeline plus exactly three whole microseconds.
    for (i = 0; i < 400 && frame_trigger !== 1'b1; i++) @(posedge core_clk);
    bound_check("delay_wait", i);
    chk("delay_cycles", 3 * ftc_pkg::CYC_PER_US + 2, i);
    settle();
    trigger_postpone_us <= 16'h0;
    // Early retrigger is refused; after readout it is refused or latched by policy.
    for (i = 0; i < 2; i++) begin
      retrigger_policy <= ftc_pkg::ftc_overlap_t'(i);
      n0 = ft_n;
      v0 = inv_n;
      fire(1);
      fire(1);
      for (k = 0; k < 400 && readout_started !== 1'b1; k++) @(posedge core_clk);
      bound_check("readout_wait", k);
      fire(1);
      settle();
      chk("overlap_frames", 1 + i, ft_n - n0);
      chk("overlap_refused", 2 - i, inv_n - v0);
    end
    retrigger_policy <= ftc_pkg::FTC_OVL_OFF;
    frame_trigger_kind_select <= ftc_pkg::FTC_KIND_MULTI;
    burst_frame_total <= 16'h3;
    run(1, 3, 0);
    burst_frame_total <= 16'h0;
    run(1, 1, 0);
    frame_trigger_kind_select <= ftc_pkg::FTC_KIND_SINGLE;
    burst_frame_total <= 16'h3;
    run(1, 1, 0);
    long_exposure_request <= 1'b1;
    quick_readout_request <= 1'b1;
    @(posedge core_clk);
    chk("quick_mode", 32'h0, {31'h0, quick_readout_mode});
    chk("long_mode", 32'h1, {31'h0, long_exposure_mode});
    long_exposure_request <= 1'b0;
    @(posedge core_clk);
    chk("quick_mode", 32'h1, {31'h0, quick_readout_mode});
    // Codes zero and seven name no line, so both flags must stay low there.
    for (i = 0; i < 8; i++) begin
      physical_line_pick <= 3'(i);
      @(posedge core_clk);
      chk("pick_in", i > 0 && i < 3, {31'h0, line_pick_is_input});
      chk("pick_out", i > 2 && i < 7, {31'h0, line_pick_is_output});
      chk("pick_index", i, {29'h0, line_pick_index});
    end
    // Reset in mid-frame must drop the frame at once, and the block must start afresh.
    fire(1);
    repeat (3) @(posedge core_clk);
    chk("frame_before_reset", 32'h1, {31'h0, frame_active});
    reset_n <= 1'b0;
    @(posedge core_clk);
    chk("reset_frame", 32'h0, {31'h0, frame_active});
    reset_n <= 1'b1;
    run(1, 1, 0);
    finish_test();
  end
endmodule : tb_frame_trigger_control
